// ===== ute_access.sv
// Special-register access to the unified translation buffer entry-high word.
// Assumes the core issues one move per cycle and holds off while busy is high.
// Assumes config_load clears the store before any entry is used.
// How it works
// - registers exist only when config level exceeds 1
// - entry-high selected by special number 0x1003
// - index register selected by special number 0x1004
// - entry-high access uses entry at current index
// - entry-high reads gated by buffer access level
// - entry-high write stores process id into entry
// - entry-high read loads entry owner into process id
// - configuration load zeroes every entry
// - core and debug resets keep buffer contents
// - bits 0:21 hold tag compared with page
// - bits 22:24 hold size, limiting tag compare
// - bit 25 valid; invalid entries never match
// - bit 26 endian reads zero, read-only
// - bit 27 user attribute reads zero, read-only
// - search sets miss flag, clears it on hit
// - index write clears miss flag
// - bits 26:31 index, loaded on search hit
// - index access needs access level above zero
// - search started by move to 0x1005
// - search compares only valid entries, size masked
`timescale 1ns/10ps
`include "ute_regs.svh"

module ute_access #(
  parameter int mmu_config_level = 2,
  parameter int buffer_access_level = 3
) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic debug_reset,
  input wire logic config_load,
  input wire logic [`UTE_SEL_W-1:0] special_reg_select,
  input wire logic move_to_special,
  input wire logic move_from_special,
  input wire logic [31:0] special_wdata,
  output logic special_ack,
  output logic [31:0] special_rdata,
  output logic busy,
  input wire logic [`UTE_TID_W-1:0] process_ident_reg,
  output logic process_ident_load,
  output logic [`UTE_TID_W-1:0] process_ident_load_data
);

  localparam bit regs_present = mmu_config_level > `UTE_MMU_REG_MIN;
  localparam bit index_access = buffer_access_level > `UTE_IX_ACCESS_MIN;
  localparam bit high_readable = (buffer_access_level == `UTE_HI_RD_LEVEL_A) ||
                                 (buffer_access_level == `UTE_HI_RD_LEVEL_B);

  ute_pkg::ute_state_t state;
  logic [`UTE_IDX_W-1:0] entry_index;
  logic miss_flag;
  logic [`UTE_IDX_W-1:0] scan_ptr;
  logic [`UTE_TAG_W-1:0] search_vpn;

  logic idle;
  logic sel_high;
  logic sel_index;
  logic sel_search;
  logic high_write;
  logic high_read;
  logic high_read_go;
  logic index_write;
  logic index_read;
  logic search_write;
  logic scan_last;
  logic entry_hit;
  logic clearing;
  logic probing;
  logic checking;
  logic reading;
  logic high_read_blocked;

  logic mem_wr_en;
  logic [`UTE_IDX_W-1:0] mem_wr_addr;
  logic [`UTE_ENT_W-1:0] mem_wr_data;
  logic mem_rd_en;
  logic [`UTE_IDX_W-1:0] mem_rd_addr;
  logic [`UTE_ENT_W-1:0] mem_rd_data;

  // Select decode; below the configuration threshold no register answers
  function automatic logic ute_sel_is(input logic [`UTE_SEL_W-1:0] sel,
                                      input logic [`UTE_SEL_W-1:0] code);
    ute_sel_is = regs_present && (sel == code);
  endfunction : ute_sel_is

  // Stored entry from a written word; fixed and reserved bits are not kept
  function automatic logic [`UTE_ENT_W-1:0] ute_pack_entry(input logic [31:0] word,
                                                          input logic [`UTE_TID_W-1:0] owner);
    ute_pack_entry = {word[`UTE_HI_TAG],
                      word[`UTE_HI_SIZE],
                      word[`UTE_HI_VALID],
                      owner};
  endfunction : ute_pack_entry

  // Entry-high word rebuilt from a stored entry
  function automatic logic [31:0] ute_high_word(input logic [`UTE_ENT_W-1:0] ent);
    ute_high_word = {ent[`UTE_ENT_TAG],
                     ent[`UTE_ENT_SIZE],
                     ent[`UTE_ENT_VALID],
                     `UTE_HI_ENDIAN_VAL,
                     `UTE_HI_USER_VAL,
                     `UTE_HI_RSVD_VAL};
  endfunction : ute_high_word

  // Index word: miss flag on top, index at the bottom
  function automatic logic [31:0] ute_index_word(input logic miss,
                                                 input logic [`UTE_IDX_W-1:0] idx);
    ute_index_word = {miss, `UTE_IX_RSVD_VAL, idx};
  endfunction : ute_index_word

  // Decode of the special-register moves; nothing answers while busy
  always_comb begin
    idle = (state == ute_pkg::st_idle);
    clearing = (state == ute_pkg::st_clear);
    probing = (state == ute_pkg::st_srch_addr);
    checking = (state == ute_pkg::st_srch_check);
    reading = (state == ute_pkg::st_hi_read);
    sel_high = ute_sel_is(special_reg_select, `UTE_SEL_ENTRY_HIGH);
    sel_index = ute_sel_is(special_reg_select, `UTE_SEL_INDEX);
    sel_search = ute_sel_is(special_reg_select, `UTE_SEL_SEARCH);
    high_write = idle && move_to_special && sel_high;
    high_read = idle && move_from_special && sel_high;
    high_read_go = high_read && high_readable;
    high_read_blocked = high_read && !high_readable;
    index_write = idle && move_to_special && sel_index && index_access;
    index_read = idle && move_from_special && sel_index;
    search_write = idle && move_to_special && sel_search;
    scan_last = (scan_ptr == `UTE_LAST_IDX);
    busy = !idle;
  end

  // Memory port steering: scans own the ports, otherwise the index does
  always_comb begin
    mem_wr_en = high_write || clearing;
    mem_wr_addr = clearing ? scan_ptr : entry_index;
    if (clearing) begin
      mem_wr_data = `UTE_ENT_CLEAR;
    end else begin
      mem_wr_data = ute_pack_entry(special_wdata, process_ident_reg);
    end
    mem_rd_en = high_read_go || probing;
    mem_rd_addr = probing ? scan_ptr : entry_index;
  end

  ute_entry_mem u_mem (
    .clock(clock),
    .wr_en(mem_wr_en),
    .wr_addr(mem_wr_addr),
    .wr_data(mem_wr_data),
    .rd_en(mem_rd_en),
    .rd_addr(mem_rd_addr),
    .rd_data(mem_rd_data)
  );

  ute_page_match u_match (
    .vpn(search_vpn),
    .tag(mem_rd_data[`UTE_ENT_TAG]),
    .size(mem_rd_data[`UTE_ENT_SIZE]),
    .valid(mem_rd_data[`UTE_ENT_VALID]),
    .match(entry_hit)
  );

  // Sequencer. Config load wins over everything, even a search in flight.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state <= ute_pkg::st_idle;
    end else if (config_load) begin
      state <= ute_pkg::st_clear;
    end else begin
      unique case (state)
        ute_pkg::st_idle: begin
          if (search_write) begin
            state <= ute_pkg::st_srch_addr;
          end else if (high_read_go) begin
            state <= ute_pkg::st_hi_read;
          end
        end
        ute_pkg::st_hi_read: begin
          state <= ute_pkg::st_idle;
        end
        ute_pkg::st_srch_addr: begin
          state <= ute_pkg::st_srch_check;
        end
        // Lowest matching index wins; a full miss walks all 64 entries
        ute_pkg::st_srch_check: begin
          if (entry_hit || scan_last) begin
            state <= ute_pkg::st_idle;
          end else begin
            state <= ute_pkg::st_srch_addr;
          end
        end
        ute_pkg::st_clear: begin
          if (scan_last) begin
            state <= ute_pkg::st_idle;
          end
        end
      endcase
    end
  end

  // Scan pointer shared by search and clear walks
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      scan_ptr <= `UTE_IDX_RESET;
    end else if (config_load || search_write) begin
      scan_ptr <= `UTE_IDX_RESET;
    end else if (clearing || (checking && !entry_hit)) begin
      scan_ptr <= scan_ptr + `UTE_IDX_STEP;
    end
  end

  // Page number under search, held for the whole walk
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      search_vpn <= '0;
    end else if (search_write) begin
      search_vpn <= special_wdata[`UTE_SX_VPN];
    end
  end

  // Entry index. Debug reset clears it; the buffer itself is untouched.
  // A failed search leaves the index where it was.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      entry_index <= `UTE_IDX_RESET;
    end else if (debug_reset) begin
      entry_index <= `UTE_IDX_RESET;
    end else if (index_write) begin
      entry_index <= special_wdata[`UTE_IX_INDEX];
    end else if (checking && entry_hit) begin
      entry_index <= scan_ptr;
    end
  end

  // Miss flag. Index writes land only while idle, so never meet a search result.
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      miss_flag <= 1'b0;
    end else if (debug_reset) begin
      miss_flag <= 1'b0;
    end else if (index_write) begin
      miss_flag <= 1'b0;
    end else if (checking && entry_hit) begin
      miss_flag <= 1'b0;
    end else if (checking && scan_last) begin
      miss_flag <= 1'b1;
    end
  end

  // Read answer strobe: index in one cycle, entry-high after the memory read
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      special_ack <= 1'b0;
    end else begin
      special_ack <= index_read || high_read_blocked || reading;
    end
  end

  // Read answer data; holds its last value between answers
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      special_rdata <= `UTE_WORD_ZERO;
    end else if (index_read) begin
      if (index_access) begin
        special_rdata <= ute_index_word(miss_flag, entry_index);
      end else begin
        special_rdata <= `UTE_WORD_ZERO;
      end
    end else if (high_read_blocked) begin
      special_rdata <= `UTE_WORD_ZERO;
    end else if (reading) begin
      special_rdata <= ute_high_word(mem_rd_data);
    end
  end

  // Owner id goes back to the process id register with the read answer
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      process_ident_load <= 1'b0;
    end else begin
      process_ident_load <= reading;
    end
  end

  // Owner id data holds between loads
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      process_ident_load_data <= `UTE_TID_ZERO;
    end else if (reading) begin
      process_ident_load_data <= mem_rd_data[`UTE_ENT_TID];
    end
  end

endmodule : ute_access

// ===== ute_access_asserts.sv
// Port assertions for the translation-entry access block.
// Assumes default levels: entry-high readable, index accessible.
`timescale 1ns/10ps
`include "ute_regs.svh"
module ute_access_chk (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic config_load,
  input wire logic [`UTE_SEL_W-1:0] special_reg_select,
  input wire logic move_to_special,
  input wire logic move_from_special,
  input wire logic special_ack,
  input wire logic [31:0] special_rdata,
  input wire logic busy,
  input wire logic process_ident_load
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  logic go, hi, ix, sx, miss_clr;
  assign go = !busy && (move_to_special || move_from_special);
  assign hi = special_reg_select == `UTE_SEL_ENTRY_HIGH;
  assign ix = special_reg_select == `UTE_SEL_INDEX;
  assign sx = special_reg_select == `UTE_SEL_SEARCH;
  // Miss known clear from reset or index write until a search
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      miss_clr <= 1'b1;
    end else if (go && move_to_special && sx) begin
      miss_clr <= 1'b0;
    end else if (go && move_to_special && ix) begin
      miss_clr <= 1'b1;
    end
  end
  chk_index_read_ack: assert property (
    go && move_from_special && ix |=> special_ack && special_rdata[30:6] == 25'h0000000)
    else $error("index read answer wrong");
  chk_high_read_time: assert property (
    go && move_from_special && hi |=> busy && !special_ack ##1 special_ack && process_ident_load && !busy)
    else $error("entry-high read timing wrong");
  chk_fixed_bits_zero: assert property (
    process_ident_load |-> special_ack && special_rdata[5:0] == 6'h00)
    else $error("fixed entry-high bits wrong");
  chk_write_no_ack: assert property (
    go && !move_from_special |=> !special_ack)
    else $error("write answered");
  chk_bad_select_quiet: assert property (
    go && !(hi || ix || sx) |=> !special_ack && !busy)
    else $error("unknown select acted");
  chk_clear_busy: assert property (
    config_load |=> busy [*8])
    else $error("clear not busy");
  chk_search_bound: assert property (
    go && move_to_special && sx |=> busy ##[1:128] !busy)
    else $error("search too long");
  chk_miss_cleared: assert property (
    go && move_from_special && ix && miss_clr |=> !special_rdata[31])
    else $error("miss flag not clear");
endmodule : ute_access_chk

// ===== ute_access_tb.sv
// Bench for the translation-entry access block.
// Assumes the core model issues moves; a shadow array holds expectations.
`timescale 1ns/10ps
`include "ute_regs.svh"
module ute_access_tb;
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic debug_reset = 1'b0;
  logic config_load = 1'b0;
  logic [13:0] special_reg_select;
  logic move_to_special, move_from_special, special_ack, busy, process_ident_load;
  logic [31:0] special_wdata, special_rdata, rd, ix;
  logic [7:0] process_ident_reg, process_ident_load_data;
  logic [31:0] shadow [64];
  logic [7:0] owner [64];
  int num_errors = 0;
  int checks_done = 0;
  int cycles = 0;
  always #25 clock = ~clock;
  ute_access i_dut (.clock, .rst_b, .debug_reset, .config_load, .special_reg_select, .move_to_special,
    .move_from_special, .special_wdata, .special_ack, .special_rdata, .busy, .process_ident_reg,
    .process_ident_load, .process_ident_load_data);
  ute_core_model i_core (.clock, .busy, .special_ack, .special_rdata, .process_ident_load,
    .process_ident_load_data, .special_reg_select, .move_to_special, .move_from_special,
    .special_wdata, .process_ident_reg);
  task automatic complete_run();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : complete_run
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      complete_run();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check
  // Lowest valid match wins; size s ignores the low 2*s tag bits
  function automatic logic [31:0] expect_search(input logic [21:0] v);
    logic [21:0] m;
    for (int k = 0; k < 64; k++) begin
      m = 22'h3fffff << (2 * shadow[k][9:7]);
      if (shadow[k][6] && ((shadow[k][31:10] ^ v) & m) == 22'h000000) begin
        return {26'h0000000, 6'(k)};
      end
    end
    return {1'b1, ix[30:0]};
  endfunction : expect_search
  task automatic put_entry(input logic [5:0] i, input logic [31:0] w, input logic [7:0] p);
    i_core.issue(`UTE_SEL_INDEX, {w[31:6], i}, 1'b0);
    i_core.process_ident_reg = p;
    i_core.issue(`UTE_SEL_ENTRY_HIGH, w, 1'b0);
    shadow[i] = w & 32'hffff_ffc0;
    owner[i] = p;
    ix = {26'h0000000, i};
  endtask : put_entry
  task automatic check_entry();
    i_core.fetch(`UTE_SEL_INDEX, rd);
    check(rd, ix);
    i_core.process_ident_reg = ~owner[ix[5:0]];
    i_core.fetch(`UTE_SEL_ENTRY_HIGH, rd);
    check(rd, shadow[ix[5:0]]);
    @(negedge clock);
    check({24'h000000, process_ident_reg}, {24'h000000, owner[ix[5:0]]});
  endtask : check_entry
  initial begin
    void'($urandom(32'h522d63a3));
    ix = 32'h0000_0000;
    repeat (10) @(negedge clock);
    rst_b = 1'b1;
    config_load = 1'b1;
    @(negedge clock);
    config_load = 1'b0;
    for (int k = 0; k < 64; k++) begin
      shadow[k] = 32'h0000_0000;
      owner[k] = 8'h00;
    end
    check_entry();
    for (int j = 0; j < 12; j++) begin
      put_entry(j == 0 ? 6'h3f : 6'($urandom), j == 0 ? 32'hffff_ffff : $urandom, 8'($urandom));
      check_entry();
    end
    for (int j = 0; j < 8; j++) begin
      rd = j[0] ? shadow[ix[5:0]] : $urandom;
      i_core.issue(`UTE_SEL_SEARCH, rd, 1'b0);
      ix = expect_search(rd[31:10]);
      check_entry();
    end
    i_core.issue(`UTE_SEL_INDEX, 32'hffff_ffc5, 1'b0);
    i_core.issue(14'h1006, 32'h0000_0000, 1'b0);
    ix = 32'h0000_0005;
    check_entry();
    debug_reset = 1'b1;
    @(negedge clock);
    debug_reset = 1'b0;
    ix = 32'h0000_0000;
    check_entry();
    rst_b = 1'b0;
    @(negedge clock);
    rst_b = 1'b1;
    i_core.issue(`UTE_SEL_INDEX, 32'h0000_003f, 1'b0);
    ix = 32'h0000_003f;
    check_entry();
    complete_run();
  end
endmodule : ute_access_tb
bind ute_access ute_access_chk i_chk (.clock, .rst_b, .config_load, .special_reg_select, .move_to_special,
  .move_from_special, .special_ack, .special_rdata, .busy, .process_ident_load);

// ===== ute_core_model.sv
// Core model: issues special-register moves and keeps the process id.
// Assumes the block's clock; drives moves on falling edges, loads the process id on rising edges.
`timescale 1ns/10ps
`include "ute_regs.svh"
module ute_core_model (
  input wire logic clock,
  input wire logic busy,
  input wire logic special_ack,
  input wire logic [31:0] special_rdata,
  input wire logic process_ident_load,
  input wire logic [`UTE_TID_W-1:0] process_ident_load_data,
  output logic [`UTE_SEL_W-1:0] special_reg_select,
  output logic move_to_special,
  output logic move_from_special,
  output logic [31:0] special_wdata,
  output logic [`UTE_TID_W-1:0] process_ident_reg
);
  initial begin
    special_reg_select = 14'h0000;
    move_to_special = 1'b0;
    move_from_special = 1'b0;
    special_wdata = 32'h0000_0000;
    process_ident_reg = 8'h00;
  end
  always @(posedge clock) begin
    if (process_ident_load) begin
      process_ident_reg <= process_ident_load_data;
    end
  end
  // Waits for idle: moves made while busy are dropped silently
  task automatic issue(input logic [13:0] sel, input logic [31:0] d, input logic rd);
    int n = 0;
    @(negedge clock);
    while (busy !== 1'b0 && n < 300) begin
      @(negedge clock);
      n++;
    end
    special_reg_select = sel;
    special_wdata = d;
    move_to_special = !rd;
    move_from_special = rd;
    @(negedge clock);
    move_to_special = 1'b0;
    move_from_special = 1'b0;
    special_reg_select = ~sel;
    special_wdata = ~d;
  endtask : issue
  task automatic fetch(input logic [13:0] sel, output logic [31:0] d);
    int n = 0;
    issue(sel, 32'h0000_0000, 1'b1);
    while (special_ack !== 1'b1 && n < 3) begin
      @(negedge clock);
      n++;
    end
    d = special_ack === 1'b1 ? special_rdata : 32'hxxxx_xxxx;
  endtask : fetch
endmodule : ute_core_model

// ===== ute_entry_mem.sv
// Translation entry store, one write and one read port, registered read data.
// Assumes the caller never writes and reads the same address in one cycle.
`timescale 1ns/10ps
`include "ute_regs.svh"

module ute_entry_mem (
  input wire logic clock,
  input wire logic wr_en,
  input wire logic [`UTE_IDX_W-1:0] wr_addr,
  input wire logic [`UTE_ENT_W-1:0] wr_data,
  input wire logic rd_en,
  input wire logic [`UTE_IDX_W-1:0] rd_addr,
  output logic [`UTE_ENT_W-1:0] rd_data
);

  // No reset: contents survive core and debug resets
  logic [`UTE_ENT_W-1:0] store [0:(1<<`UTE_IDX_W)-1];

  always_ff @(posedge clock) begin
    if (wr_en) begin
      store[wr_addr] <= wr_data;
    end
  end

  always_ff @(posedge clock) begin
    if (rd_en) begin
      rd_data <= store[rd_addr];
    end
  end

endmodule : ute_entry_mem

// ===== ute_page_match.sv
// Compares a virtual page number against one stored entry under its size.
// Purely combinational; fed from registered memory data.
`timescale 1ns/10ps
`include "ute_regs.svh"

module ute_page_match (
  input wire logic [`UTE_TAG_W-1:0] vpn,
  input wire logic [`UTE_TAG_W-1:0] tag,
  input wire logic [`UTE_SIZE_W-1:0] size,
  input wire logic valid,
  output logic match
);

  // Each size step drops two more low tag bits from the compare
  function automatic logic [`UTE_TAG_W-1:0] ute_size_mask(input logic [`UTE_SIZE_W-1:0] sz);
    ute_size_mask = {`UTE_TAG_W{1'b1}} << {sz, 1'b0};
  endfunction : ute_size_mask

  always_comb begin
    match = valid && (((vpn ^ tag) & ute_size_mask(size)) == '0);
  end

endmodule : ute_page_match

// ===== ute_pkg.sv
// Types shared by the translation-entry access block.
// Assumes ute_regs.svh holds all numeric constants.
package ute_pkg;

  typedef enum logic [2:0] {
    st_idle,
    st_hi_read,
    st_srch_addr,
    st_srch_check,
    st_clear
  } ute_state_t;

endpackage : ute_pkg

// ===== ute_regs.svh
// Constants for the translation-entry special-register path.
// Assumes big-endian field numbering: field bit n sits at word bit 31-n.
`ifndef UTE_REGS_SVH
`define UTE_REGS_SVH

`define UTE_SEL_W 14
`define UTE_SEL_ENTRY_HIGH 14'h1003
`define UTE_SEL_INDEX 14'h1004
`define UTE_SEL_SEARCH 14'h1005

`define UTE_IDX_W 6
`define UTE_LAST_IDX 6'h3f
`define UTE_IDX_RESET 6'h00
`define UTE_IDX_STEP 6'h01
`define UTE_TID_W 8
`define UTE_TAG_W 22
`define UTE_SIZE_W 3

// Stored entry: tag, size, valid, owner id
`define UTE_ENT_W 34
`define UTE_ENT_TAG 33:12
`define UTE_ENT_SIZE 11:9
`define UTE_ENT_VALID 8
`define UTE_ENT_TID 7:0
`define UTE_ENT_CLEAR 34'h0_0000_0000

// Entry-high word fields
`define UTE_HI_TAG 31:10
`define UTE_HI_SIZE 9:7
`define UTE_HI_VALID 6
`define UTE_HI_ENDIAN_VAL 1'h0
`define UTE_HI_USER_VAL 1'h0
`define UTE_HI_RSVD_VAL 4'h0

// Index word fields
`define UTE_IX_RSVD_VAL 25'h0000000
`define UTE_IX_INDEX 5:0

// Search word field
`define UTE_SX_VPN 31:10

`define UTE_WORD_ZERO 32'h0000_0000
`define UTE_TID_ZERO 8'h00

// Configuration thresholds
`define UTE_MMU_REG_MIN 1
`define UTE_IX_ACCESS_MIN 0
`define UTE_HI_RD_LEVEL_A 1
`define UTE_HI_RD_LEVEL_B 3

`endif
